//--- pkg/pin_sync_if.sv
`timescale 1ns/1ps

interface pin_sync_if;
	logic scl;
	logic sda;
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;

	modport producer (
		output scl,
		output sda,
		output scl_rise,
		output scl_fall,
		output start_seen,
		output stop_seen
	);

	modport consumer (
		input scl,
		input sda,
		input scl_rise,
		input scl_fall,
		input start_seen,
		input stop_seen
	);
endinterface

//--- pkg/pmon_defines.svh
`ifndef PMON_DEFINES_SVH
`define PMON_DEFINES_SVH

// ----------------------------------------
// bus address
// ----------------------------------------
`define ADDR_BASE 5'h0b
`define ADDR_STRAP_GND 2'h0
`define ADDR_STRAP_RES 2'h1
`define ADDR_STRAP_FLOAT 2'h2
`define ADDR_STRAP_HIGH 2'h3

// ----------------------------------------
// command byte fields
// ----------------------------------------
`define CMD_VOLT_CONT 0
`define CMD_VOLT_ONCE 1
`define CMD_AMP_CONT 2
`define CMD_AMP_ONCE 3
`define CMD_VOLT_DIV 4
`define CMD_STATUS_RD 6
`define CMD_EXTENDED 7
`define CMD_RESET 8'h00

// ----------------------------------------
// timing
// ----------------------------------------
`define SCL_MAX_KHZ 400
`define SYS_CLK_MHZ 250
`define SCL_MIN_CYCLES ((`SYS_CLK_MHZ * 1000) / `SCL_MAX_KHZ)

`endif

//--- pkg/pmon_pkg.sv
package pmon_pkg;

	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_ADDR = 6'h02,
		ST_ACK = 6'h04,
		ST_WRITE = 6'h08,
		ST_READ = 6'h10,
		ST_IGNORE = 6'h20
	} bus_state_t;

	typedef enum logic [1:0] {
		RD_BOTH = 2'h0,
		RD_VOLT = 2'h1,
		RD_AMP = 2'h2,
		RD_STATUS = 2'h3
	} read_kind_t;

endpackage

//--- verif/i2c_master_model.sv
`timescale 1ns/1ps
// ----
// bus master model
// ----
module i2c_master_model (
	output logic scl,
	output logic sda_low,
	input wire logic sda
);
	// clock stands high between frames
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic bit_io(input logic b, output logic r);
		#40 sda_low = !b;
		#40 scl = 1'b1;
		#40 r = sda;
		#40 scl = 1'b0;
	endtask
	task automatic start_cond;
		#40 sda_low = 1'b0;
		#40 scl = 1'b1;
		#40 sda_low = 1'b1;
		#40 scl = 1'b0;
	endtask
	task automatic stop_cond;
		#40 sda_low = 1'b1;
		#40 scl = 1'b1;
		#40 sda_low = 1'b0;
		#40;
	endtask
	task automatic wr(input logic [7:0] b, output logic ack);
		logic r;
		for (int k = 7; k >= 0; k--) bit_io(b[k], r);
		bit_io(1'b1, r);
		ack = !r;
	endtask
	// last byte gets no acknowledge so the slave lets go
	task automatic rd(input logic last, output logic [7:0] b);
		logic r;
		for (int k = 7; k >= 0; k--) bit_io(1'b1, b[k]);
		bit_io(last, r);
	endtask
endmodule

//--- verif/pmon_checker.sv
`timescale 1ns/1ps
// ----
// port checks
// ----
module pmon_checker (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic scl_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic volt_continuous,
	input wire logic amp_continuous,
	input wire logic volt_divider_select,
	input wire logic volt_once_start,
	input wire logic amp_once_start,
	input wire logic status_read_sel,
	input wire logic ext_cmd_valid
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	wire logic [3:0] cmd_w = {status_read_sel, volt_divider_select,
		amp_continuous, volt_continuous};
	sequence scl_high2;
		scl_in ##1 scl_in;
	endsequence
	sequence oe_held;
		sda_oe [*8];
	endsequence
	AST_RESET_ZERO:
		assert property ($rose(reset_n) |-> cmd_w == 4'h0 && !sda_oe)
		else $error("outputs not clear after reset");
	AST_OPEN_DRAIN:
		assert property (sda_oe |-> sda_out == 1'b0)
		else $error("sda driven high");
	AST_ACK_HOLD:
		assert property ($rose(sda_oe) |-> oe_held)
		else $error("sda pull released early");
	AST_OE_STABLE:
		assert property (scl_high2 |-> $stable(sda_oe))
		else $error("sda moved while scl high");
	AST_CMD_ON_SCL_HIGH:
		assert property ($changed(cmd_w) |-> scl_in)
		else $error("command bits moved outside a data bit");
	AST_VONCE_PULSE:
		assert property (volt_once_start |-> scl_in ##1 !volt_once_start)
		else $error("voltage start not one cycle");
	AST_AONCE_PULSE:
		assert property (amp_once_start |=> !amp_once_start)
		else $error("current start not one cycle");
	AST_EXT_PULSE:
		assert property (ext_cmd_valid |=> !ext_cmd_valid)
		else $error("extended strobe not one cycle");
	AST_EXT_EXCL:
		assert property (ext_cmd_valid |-> !volt_once_start &&
			!amp_once_start && $stable(cmd_w))
		else $error("extended byte acted as a command");
endmodule

bind power_monitor_i2c_command_port pmon_checker u_pmon_checker (
	.sys_clk, .reset_n, .scl_in, .sda_out, .sda_oe, .volt_continuous,
	.amp_continuous, .volt_divider_select, .volt_once_start,
	.amp_once_start, .status_read_sel, .ext_cmd_valid);

//--- verif/power_monitor_i2c_command_port_tb.sv
`timescale 1ns/1ps
`include "pmon_defines.svh"
// ----
// bench top
// ----
module power_monitor_i2c_command_port_tb;
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	logic [1:0] addr_strap = 2'h0;
	logic [11:0] volt_result = 12'h000;
	logic [11:0] amp_result = 12'h000;
	logic volt_done = 1'b0;
	logic amp_done = 1'b0;
	logic [7:0] status_byte = 8'h00;
	logic scl, sda_low, sda_out, sda_oe, ack, volt_continuous, amp_continuous;
	logic volt_divider_select, volt_once_start, amp_once_start;
	logic status_read_sel, ext_cmd_valid;
	logic [6:0] ext_cmd_byte, eb_l;
	logic [7:0] rb [3];
	int n_fail = 0;
	int cmp_count = 0;
	int n_vo = 0, n_ao = 0, n_ev = 0;
	wire sda = !((sda_oe && !sda_out) || sda_low);
	wire [6:0] dev = {`ADDR_BASE, addr_strap};
	wire [3:0] cmd_o = {status_read_sel, volt_divider_select,
		amp_continuous, volt_continuous};

	power_monitor_i2c_command_port u_power_monitor_i2c_command_port (
		.sys_clk, .reset_n, .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe,
		.addr_strap, .volt_result, .amp_result, .volt_done, .amp_done,
		.status_byte, .volt_continuous, .amp_continuous,
		.volt_divider_select, .volt_once_start, .amp_once_start,
		.status_read_sel, .ext_cmd_byte, .ext_cmd_valid);
	i2c_master_model u_i2c_master_model (.scl, .sda_low, .sda);

	always #2 sys_clk = !sys_clk;
	always @(posedge sys_clk) begin
		n_vo <= n_vo + volt_once_start;
		n_ao <= n_ao + amp_once_start;
		n_ev <= n_ev + ext_cmd_valid;
		if (ext_cmd_valid) eb_l <= ext_cmd_byte;
	end

	task automatic chk(input string nm, input logic [11:0] e, g);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task end_of_test;
		$display("checks %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// kind: 0 both, 1 volt, 2 amp, 3 status, 4 not yet converted
	function automatic logic [7:0] fmt(input int k, input int n);
		logic [11:0] a;
		a = (k == 2) ? amp_result : volt_result;
		if (k == 3) return status_byte;
		if (k == 4) return 8'h00;
		if (k == 0) return (n == 0) ? volt_result[11:4] : (n == 1) ?
			amp_result[11:4] : {volt_result[3:0], amp_result[3:0]};
		return (n == 0) ? a[11:4] : {a[3:0], 4'h0};
	endfunction
	task automatic addr(input logic [7:0] a);
		@(negedge sys_clk);
		u_i2c_master_model.start_cond();
		u_i2c_master_model.wr(a, ack);
		u_i2c_master_model.stop_cond();
	endtask
	task automatic wcmd(input logic [7:0] c);
		logic a1;
		@(negedge sys_clk);
		u_i2c_master_model.start_cond();
		u_i2c_master_model.wr({dev, 1'b0}, a1);
		u_i2c_master_model.wr(c, ack);
		u_i2c_master_model.stop_cond();
		chk("wr_ack", 12'h3, {a1, ack});
	endtask
	// kind 5 checks the acknowledge only
	task automatic rx(input int n, input int k, input logic ea);
		@(negedge sys_clk);
		u_i2c_master_model.start_cond();
		u_i2c_master_model.wr({dev, 1'b1}, ack);
		for (int j = 0; j < n; j++)
			if (ack) u_i2c_master_model.rd(j == n - 1, rb[j]);
		u_i2c_master_model.stop_cond();
		chk("rd_ack", ea, ack);
		for (int j = 0; j < n; j++)
			if (ea && k < 5) chk("rd_byte", fmt(k, j), rb[j]);
	endtask
	task automatic pulse(input logic v, input logic a);
		@(negedge sys_clk);
		volt_done = v;
		amp_done = a;
		@(negedge sys_clk);
		volt_done = 1'b0;
		amp_done = 1'b0;
	endtask

	initial begin
		repeat (50000) @(posedge sys_clk);
		n_fail++;
		end_of_test();
	end
	initial begin
		logic [7:0] c;
		int vo, ao;
		void'($urandom(32'h695a));
		volt_result = 12'($urandom);
		amp_result = 12'($urandom);
		repeat (5) @(posedge sys_clk);
		@(negedge sys_clk);
		reset_n = 1'b1;
		chk("reset_out", 12'h0, {cmd_o, volt_once_start});
		repeat (8) @(negedge sys_clk);
		for (int s = 0; s < 4; s++) begin
			addr_strap = 2'(s);
			repeat (4) @(negedge sys_clk);
			addr({dev, 1'b0});
			chk("quick_ack", 1'b1, ack);
			addr({dev ^ (s[0] ? 7'h40 : 7'h02), 1'b0});
			chk("miss_ack", 1'b0, ack);
		end
		chk("quick_keep", 12'h0, cmd_o);
		$display("test address done");
		wcmd(8'h01);
		rx(2, 4, 1'b1);
		wcmd(8'h04);
		rx(2, 4, 1'b1);
		wcmd(8'h08);
		rx(2, 2, 1'b0);
		pulse(1'b0, 1'b1);
		rx(2, 2, 1'b1);
		wcmd(8'h02);
		rx(2, 5, 1'b0);
		pulse(1'b1, 1'b0);
		rx(2, 5, 1'b1);
		wcmd(8'h05);
		volt_result = 12'($urandom);
		amp_result = 12'($urandom);
		pulse(1'b1, 1'b1);
		rx(3, 0, 1'b1);
		status_byte = 8'($urandom);
		wcmd(8'h45);
		rx(2, 3, 1'b1);
		$display("test readback done");
		c = 8'h80 | 8'($urandom);
		vo = n_ev;
		wcmd(c);
		chk("ext_byte", c[6:0], eb_l);
		chk("ext_keep", 12'h01b, {8'(n_ev - vo), cmd_o});
		for (int i = 0; i < 8; i++) begin
			c = (i == 0) ? 8'h5f : 8'($urandom) & 8'h5f;
			vo = n_vo;
			ao = n_ao;
			wcmd(c);
			chk("cmd_bits", {c[6], c[4], c[2], c[0]}, cmd_o);
			chk("once_cnt", {3'h0, c[3], 3'h0, c[1]},
				{4'(n_ao - ao), 4'(n_vo - vo)});
		end
		$display("test commands done");
		end_of_test();
	end
endmodule

//--- verilog/bus_line_sync.sv
`timescale 1ns/1ps

module bus_line_sync (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic scl_in,
	input wire logic sda_in,
	pin_sync_if.producer pins
);

	logic [2:0] scl_sh_r;
	logic [2:0] sda_sh_r;
	logic scl_r;
	logic sda_r;

	// ----------------------------------------
	// three-stage samplers, change taken when stages two and three agree
	// ----------------------------------------
	wire scl_agree = (scl_sh_r[1] == scl_sh_r[2]);
	wire sda_agree = (sda_sh_r[1] == sda_sh_r[2]);
	wire scl_nxt = scl_agree ? scl_sh_r[2] : scl_r;
	wire sda_nxt = sda_agree ? sda_sh_r[2] : sda_r;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			scl_sh_r <= 3'h7;
			sda_sh_r <= 3'h7;
			scl_r <= 1'b1;
			sda_r <= 1'b1;
		end else begin
			scl_sh_r <= {scl_sh_r[1:0], scl_in};
			sda_sh_r <= {sda_sh_r[1:0], sda_in};
			scl_r <= scl_nxt;
			sda_r <= sda_nxt;
		end
	end

	assign pins.scl = scl_r;
	assign pins.sda = sda_r;
	assign pins.scl_rise = scl_nxt & ~scl_r;
	assign pins.scl_fall = ~scl_nxt & scl_r;
	// sda falling while scl high
	assign pins.start_seen = scl_r & scl_nxt & sda_r & ~sda_nxt;
	// sda rising while scl high
	assign pins.stop_seen = scl_r & scl_nxt & ~sda_r & sda_nxt;

endmodule

//--- verilog/power_monitor_i2c_command_port.sv
`timescale 1ns/1ps
`include "pmon_defines.svh"

// Function
// - bus address upper five bits fixed at the base pattern
// - low two address bits follow the four-state strap pin
// - start is sda falling with scl high; then shift eight bits
// - first byte: seven address bits msb first, then direction bit
// - on match pull sda low for the ninth clock, else ignore the frame until the next start or stop
// - each unit is eight data bits plus one acknowledge bit
// - sda change only while scl low; rise with scl high is stop
// - first byte after address in a write is the command byte
// - quick command is acknowledged and changes no setting
// - command write: start, address, ack, command, ack, stop
// - command msb zero is ordinary; msb one is extended write
// - bit0 continuous voltage; early reads acked with zero data
// - bit1 one voltage conversion, self-clears; reads nacked until done
// - bit2 continuous current; early reads acked with zero data
// - bit3 one current conversion, self-clears; reads nacked until done
// - bit4 picks voltage divider: 0 fourteen-to-one, 1 seven-to-two
// - while bit6 set, read returns the alert status byte
// - twelve-bit results returned in two or three read bytes
// - accepts fast-mode scl up to 400 khz
// - both channels: v[11:4], i[11:4], then v[3:0] over i[3:0]
// - one channel: bits 11..4, then bits 3..0 with low nibble zero
module power_monitor_i2c_command_port (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic [1:0] addr_strap,
	input wire logic [11:0] volt_result,
	input wire logic [11:0] amp_result,
	input wire logic volt_done,
	input wire logic amp_done,
	input wire logic [7:0] status_byte,
	output logic volt_continuous,
	output logic amp_continuous,
	output logic volt_divider_select,
	output logic volt_once_start,
	output logic amp_once_start,
	output logic status_read_sel,
	output logic [6:0] ext_cmd_byte,
	output logic ext_cmd_valid
);

	pin_sync_if pins ();

	bus_line_sync u_sync (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.pins(pins.producer)
	);

	// ----------------------------------------
	// state
	// ----------------------------------------
	pmon_pkg::bus_state_t state_r;
	pmon_pkg::bus_state_t state_nxt;
	logic [3:0] bit_cnt_r;
	logic [7:0] shift_r;
	logic is_read_r;
	logic got_cmd_r;
	logic ack_drive_r;
	logic master_ack_r;
	logic [1:0] byte_idx_r;
	logic [7:0] tx_r;
	logic [7:0] cmd_r;
	logic [1:0] strap_r;
	logic volt_valid_r;
	logic amp_valid_r;
	logic volt_pend_r;
	logic amp_pend_r;
	logic volt_start_r;
	logic amp_start_r;
	logic [6:0] ext_r;
	logic ext_valid_r;
	logic [11:0] volt_hold_r;
	logic [11:0] amp_hold_r;

	// scl up to 400 khz gives at least this many sys_clk cycles per period
	localparam int SCL_MIN_CYC = `SCL_MIN_CYCLES;

	// ----------------------------------------
	// decode
	// ----------------------------------------
	wire [6:0] my_addr = {`ADDR_BASE, strap_r};
	wire [7:0] byte_in = {shift_r[6:0], pins.sda};
	wire addr_match = (byte_in[7:1] == my_addr);
	wire byte_end = pins.scl_rise & (bit_cnt_r == 4'h7);
	wire ninth_fall = pins.scl_fall & (bit_cnt_r == 4'h8);
	wire volt_busy = volt_pend_r;
	wire amp_busy = amp_pend_r;
	// one-shot not finished: refuse the read
	wire read_ok = ~volt_busy & ~amp_busy;
	wire is_cmd = ~byte_in[`CMD_EXTENDED];
	wire want_v = cmd_r[`CMD_VOLT_CONT] | volt_pend_r | volt_valid_r;
	wire want_i = cmd_r[`CMD_AMP_CONT] | amp_pend_r | amp_valid_r;
	// results not yet produced read as zero, never stale
	wire [11:0] v_data = volt_valid_r ? volt_hold_r : 12'h000;
	wire [11:0] i_data = amp_valid_r ? amp_hold_r : 12'h000;
	wire status_mode = cmd_r[`CMD_STATUS_RD];
	wire both_mode = want_v & want_i;

	pmon_pkg::read_kind_t kind;
	assign kind = status_mode ? pmon_pkg::RD_STATUS :
		both_mode ? pmon_pkg::RD_BOTH :
		want_i ? pmon_pkg::RD_AMP : pmon_pkg::RD_VOLT;

	logic [7:0] tx_sel;
	always_comb begin
		tx_sel = 8'h00;
		case (kind)
			pmon_pkg::RD_STATUS: tx_sel = status_byte;
			pmon_pkg::RD_BOTH: begin
				case (byte_idx_r)
					2'h0: tx_sel = v_data[11:4];
					2'h1: tx_sel = i_data[11:4];
					2'h2: tx_sel = {v_data[3:0], i_data[3:0]};
					default: tx_sel = 8'h00;
				endcase
			end
			pmon_pkg::RD_AMP: begin
				case (byte_idx_r)
					2'h0: tx_sel = i_data[11:4];
					2'h1: tx_sel = {i_data[3:0], 4'h0};
					default: tx_sel = 8'h00;
				endcase
			end
			default: begin
				case (byte_idx_r)
					2'h0: tx_sel = v_data[11:4];
					2'h1: tx_sel = {v_data[3:0], 4'h0};
					default: tx_sel = 8'h00;
				endcase
			end
		endcase
	end

	// ----------------------------------------
	// transaction state machine
	// ----------------------------------------
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			pmon_pkg::ST_IDLE: state_nxt = state_r;
			pmon_pkg::ST_ADDR: begin
				if (byte_end) begin
					// refused reads and foreign addresses fall silent
					if (addr_match & (~byte_in[0] | read_ok)) begin
						state_nxt = pmon_pkg::ST_ACK;
					end else begin
						state_nxt = pmon_pkg::ST_IGNORE;
					end
				end
			end
			pmon_pkg::ST_ACK: begin
				if (ninth_fall) begin
					state_nxt = is_read_r ? pmon_pkg::ST_READ :
						pmon_pkg::ST_WRITE;
				end
			end
			pmon_pkg::ST_WRITE: begin
				if (byte_end) begin
					state_nxt = pmon_pkg::ST_ACK;
				end
			end
			pmon_pkg::ST_READ: begin
				if (pins.scl_rise & (bit_cnt_r == 4'h8) & pins.sda) begin
					state_nxt = pmon_pkg::ST_IGNORE;
				end
			end
			pmon_pkg::ST_IGNORE: state_nxt = state_r;
			default: state_nxt = pmon_pkg::ST_IDLE;
		endcase
		if (pins.start_seen) begin
			state_nxt = pmon_pkg::ST_ADDR;
		end else if (pins.stop_seen) begin
			state_nxt = pmon_pkg::ST_IDLE;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= pmon_pkg::ST_IDLE;
			bit_cnt_r <= 4'h0;
			shift_r <= 8'h00;
		end else begin
			state_r <= state_nxt;
			shift_r <= pins.scl_rise ? byte_in : shift_r;
			if (pins.start_seen) begin
				// the scl fall that follows start wraps this to zero
				bit_cnt_r <= 4'hf;
			end else if (ninth_fall) begin
				bit_cnt_r <= 4'h0;
			end else if (pins.scl_fall) begin
				bit_cnt_r <= bit_cnt_r + 4'h1;
			end
		end
	end

	// ----------------------------------------
	// transaction flags and read pointer
	// ----------------------------------------
	wire addr_acked = (state_r == pmon_pkg::ST_ADDR) &
		(state_nxt == pmon_pkg::ST_ACK);
	wire cmd_taken = (state_r == pmon_pkg::ST_WRITE) & byte_end & ~got_cmd_r;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			is_read_r <= 1'b0;
			got_cmd_r <= 1'b0;
			byte_idx_r <= 2'h0;
			master_ack_r <= 1'b0;
		end else begin
			if (addr_acked) begin
				is_read_r <= byte_in[0];
				got_cmd_r <= 1'b0;
				byte_idx_r <= 2'h0;
			end else if (cmd_taken) begin
				got_cmd_r <= 1'b1;
			end
			// advance with every load so the next byte is picked, not repeated
			if (ninth_fall & (state_nxt == pmon_pkg::ST_READ)) begin
				byte_idx_r <= byte_idx_r + 2'h1;
			end
			master_ack_r <= (state_r == pmon_pkg::ST_READ) &
				(bit_cnt_r == 4'h8);
		end
	end

	// ----------------------------------------
	// sda drive: ack in ninth slot or read data, set on scl low
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			ack_drive_r <= 1'b0;
			tx_r <= 8'h00;
		end else begin
			// acknowledge goes low after the eighth falling edge
			if (pins.scl_fall & (bit_cnt_r == 4'h7) &
				((state_r == pmon_pkg::ST_ACK) |
				(state_r == pmon_pkg::ST_WRITE &
				state_nxt == pmon_pkg::ST_ACK))) begin
				ack_drive_r <= 1'b1;
			end else if (ninth_fall | pins.stop_seen | pins.start_seen) begin
				ack_drive_r <= 1'b0;
			end
			if (ninth_fall & (state_nxt == pmon_pkg::ST_READ)) begin
				tx_r <= tx_sel;
			end else if ((state_r == pmon_pkg::ST_READ) & pins.scl_fall &
				(bit_cnt_r < 4'h7)) begin
				tx_r <= {tx_r[6:0], 1'b0};
			end
		end
	end

	wire tx_slot = (state_r == pmon_pkg::ST_READ) & (bit_cnt_r < 4'h8);
	assign sda_out = 1'b0;
	// open drain: only ever pull low
	assign sda_oe = ack_drive_r | (tx_slot & ~tx_r[7]);

	// ----------------------------------------
	// command register and conversion bookkeeping
	// ----------------------------------------
	wire cmd_load = cmd_taken & is_cmd;
	wire ext_load = cmd_taken & ~is_cmd;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			cmd_r <= `CMD_RESET;
			strap_r <= 2'h0;
			volt_start_r <= 1'b0;
			amp_start_r <= 1'b0;
			ext_r <= 7'h00;
			ext_valid_r <= 1'b0;
		end else begin
			// strap captured while the bus is idle, never mid-transaction
			if (state_r == pmon_pkg::ST_IDLE) begin
				strap_r <= addr_strap;
			end
			volt_start_r <= cmd_load & byte_in[`CMD_VOLT_ONCE];
			amp_start_r <= cmd_load & byte_in[`CMD_AMP_ONCE];
			ext_valid_r <= ext_load;
			if (cmd_load) begin
				// once bits self-clear: stored as zero
				cmd_r <= {1'b0, byte_in[6:4], 1'b0, byte_in[2], 1'b0,
					byte_in[0]};
			end
			if (ext_load) begin
				ext_r <= byte_in[6:0];
			end
		end
	end

	// a fresh start wins over a done in the same cycle
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			volt_pend_r <= 1'b0;
			amp_pend_r <= 1'b0;
			volt_valid_r <= 1'b0;
			amp_valid_r <= 1'b0;
			volt_hold_r <= 12'h000;
			amp_hold_r <= 12'h000;
		end else begin
			if (volt_start_r) begin
				volt_pend_r <= 1'b1;
				volt_valid_r <= 1'b0;
			end else if (volt_done) begin
				volt_pend_r <= 1'b0;
				volt_valid_r <= 1'b1;
				volt_hold_r <= volt_result;
			end
			if (amp_start_r) begin
				amp_pend_r <= 1'b1;
				amp_valid_r <= 1'b0;
			end else if (amp_done) begin
				amp_pend_r <= 1'b0;
				amp_valid_r <= 1'b1;
				amp_hold_r <= amp_result;
			end
		end
	end

	assign volt_continuous = cmd_r[`CMD_VOLT_CONT];
	assign amp_continuous = cmd_r[`CMD_AMP_CONT];
	assign volt_divider_select = cmd_r[`CMD_VOLT_DIV];
	assign status_read_sel = cmd_r[`CMD_STATUS_RD];
	assign volt_once_start = volt_start_r;
	assign amp_once_start = amp_start_r;
	assign ext_cmd_byte = ext_r;
	assign ext_cmd_valid = ext_valid_r;

endmodule
